// *** rtl/scc_map.svh ***
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_ADDR_SOFT_RESET 16'hFF0C
`define SCC_ADDR_RESAMPLE_SEL 16'hFF0D
`define SCC_ADDR_CLK_OUT_CFG 16'hFF1F
`define SCC_MMD_SUBSYS 5'h1E
`define SCC_RST_SOFT_RESET 16'h0000
`define SCC_RST_RESAMPLE_SEL 16'h0000
`define SCC_RST_CLK_OUT_CFG 16'h0000
`define SCC_BIT_SOFT_RESET 0
`define SCC_BIT_RESAMPLE 0
`define SCC_BIT_RCVR_FAST 5
`define SCC_BIT_FREE_FAST 4
`define SCC_BIT_RSVD3 3
`define SCC_BIT_RCVR_HRT 2
`define SCC_BIT_FREE_HRT 1
`define SCC_BIT_REF 0
`define SCC_CLK_CFG_MASK 16'h003F
`define SCC_SOFT_RESET_CYCLES 4'h8
`endif

// *** rtl/scc_pkg.sv ***
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_SRC_NONE = 3'h0,
    SCC_SRC_REF = 3'h1,
    SCC_SRC_FREE_HRT = 3'h3,
    SCC_SRC_RCVR_HRT = 3'h2,
    SCC_SRC_FREE_FAST = 3'h6,
    SCC_SRC_RCVR_FAST = 3'h7
  } scc_src_type;
  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'h0,
    SCC_ST_RESET = 2'h1,
    SCC_ST_LOAD = 2'h3
  } scc_state_type;
  typedef struct packed {
    logic req;
    logic wr;
    logic [4:0] mmd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } scc_mgmt_req_type;
  typedef struct packed {
    logic ack;
    logic hit;
    logic [15:0] rdata;
  } scc_mgmt_rsp_type;
endpackage

// *** rtl/scc_subsys_clk_rst.sv ***
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_subsys_clk_rst
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Management access from the serial frame decoder, same clock
  input wire scc_mgmt_req_type mgmt_req_i,
  output scc_mgmt_rsp_type mgmt_rsp_o,
  // Candidate clock sources, gated internally
  input wire logic rcvr_fast_clk_i,
  input wire logic free_fast_clk_i,
  input wire logic rcvr_hrt_clk_i,
  input wire logic free_hrt_clk_i,
  input wire logic ref_clk_i,
  // General clock pin
  output logic general_clock_out_pin_o,
  output logic general_clock_out_oe_o,
  output scc_src_type clk_src_o,
  // Subsystem reset sequence
  output logic subsys_reset_o,
  output logic pin_resample_req_o,
  output logic pin_reload_req_o
);
  logic rst_s1_r;
  logic rst_s2_r;
  logic resample_sel_r;
  logic [5:0] clk_cfg_r;
  logic reset_pend_r;
  logic mode_r;
  logic [3:0] cnt_r;
  scc_state_type state_r;
  scc_src_type src_nxt;
  logic hit;
  logic wr_en;
  logic [15:0] rdata_nxt;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign hit = mgmt_req_i.req && (mgmt_req_i.mmd == `SCC_MMD_SUBSYS) &&
    (mgmt_req_i.addr == `SCC_ADDR_SOFT_RESET || mgmt_req_i.addr == `SCC_ADDR_RESAMPLE_SEL ||
     mgmt_req_i.addr == `SCC_ADDR_CLK_OUT_CFG);
  assign wr_en = hit && mgmt_req_i.wr;

  always_ff @(posedge sys_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      resample_sel_r <= 1'(`SCC_RST_RESAMPLE_SEL);
      clk_cfg_r <= 6'(`SCC_RST_CLK_OUT_CFG);
    end else if (wr_en) begin
      if (mgmt_req_i.addr == `SCC_ADDR_RESAMPLE_SEL) begin
        resample_sel_r <= mgmt_req_i.wdata[`SCC_BIT_RESAMPLE];
      end
      // Reserved bit 3 is kept for read-back but never selects a source
      if (mgmt_req_i.addr == `SCC_ADDR_CLK_OUT_CFG) begin
        clk_cfg_r <= mgmt_req_i.wdata[5:0];
      end
    end
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    if (mgmt_req_i.addr == `SCC_ADDR_SOFT_RESET) begin
      rdata_nxt[`SCC_BIT_SOFT_RESET] = reset_pend_r;
    end else if (mgmt_req_i.addr == `SCC_ADDR_RESAMPLE_SEL) begin
      rdata_nxt[`SCC_BIT_RESAMPLE] = resample_sel_r;
    end else if (mgmt_req_i.addr == `SCC_ADDR_CLK_OUT_CFG) begin
      rdata_nxt[5:0] = clk_cfg_r;
    end
  end

  // Answer one cycle after each request; unmapped reads give zero with hit low
  always_ff @(posedge sys_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      mgmt_rsp_o <= '0;
    end else begin
      mgmt_rsp_o.ack <= mgmt_req_i.req;
      mgmt_rsp_o.hit <= hit;
      mgmt_rsp_o.rdata <= hit ? rdata_nxt : 16'h0000;
    end
  end

  // Soft reset sequence; trigger bit self-clears when the sequence ends
  always_ff @(posedge sys_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= SCC_ST_IDLE;
      reset_pend_r <= 1'(`SCC_RST_SOFT_RESET);
      mode_r <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        // Selector is latched here so a later write cannot alter a running sequence
        SCC_ST_IDLE: begin
          if (wr_en && mgmt_req_i.addr == `SCC_ADDR_SOFT_RESET &&
              mgmt_req_i.wdata[`SCC_BIT_SOFT_RESET]) begin
            state_r <= SCC_ST_RESET;
            reset_pend_r <= 1'b1;
            mode_r <= resample_sel_r;
            cnt_r <= `SCC_SOFT_RESET_CYCLES;
          end
        end
        SCC_ST_RESET: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            state_r <= SCC_ST_LOAD;
          end
        end
        SCC_ST_LOAD: begin
          state_r <= SCC_ST_IDLE;
          reset_pend_r <= 1'b0;
        end
        default: state_r <= SCC_ST_IDLE;
      endcase
    end
  end

  assign subsys_reset_o = (state_r == SCC_ST_RESET);
  assign pin_resample_req_o = (state_r == SCC_ST_LOAD) && mode_r;
  assign pin_reload_req_o = (state_r == SCC_ST_LOAD) && !mode_r;

  // Fixed priority keeps a single source on the pin
  always_comb begin
    if (clk_cfg_r[`SCC_BIT_RCVR_FAST]) begin
      src_nxt = SCC_SRC_RCVR_FAST;
    end else if (clk_cfg_r[`SCC_BIT_FREE_FAST]) begin
      src_nxt = SCC_SRC_FREE_FAST;
    end else if (clk_cfg_r[`SCC_BIT_RCVR_HRT]) begin
      src_nxt = SCC_SRC_RCVR_HRT;
    end else if (clk_cfg_r[`SCC_BIT_FREE_HRT]) begin
      src_nxt = SCC_SRC_FREE_HRT;
    end else if (clk_cfg_r[`SCC_BIT_REF]) begin
      src_nxt = SCC_SRC_REF;
    end else begin
      src_nxt = SCC_SRC_NONE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      clk_src_o <= SCC_SRC_NONE;
    end else begin
      clk_src_o <= src_nxt;
    end
  end

  // Clock path is a plain mux; a glitch can occur at the instant the source changes
  always_comb begin
    case (clk_src_o)
      SCC_SRC_RCVR_FAST: general_clock_out_pin_o = rcvr_fast_clk_i;
      SCC_SRC_FREE_FAST: general_clock_out_pin_o = free_fast_clk_i;
      SCC_SRC_RCVR_HRT: general_clock_out_pin_o = rcvr_hrt_clk_i;
      SCC_SRC_FREE_HRT: general_clock_out_pin_o = free_hrt_clk_i;
      SCC_SRC_REF: general_clock_out_pin_o = ref_clk_i;
      default: general_clock_out_pin_o = 1'b0;
    endcase
  end
  assign general_clock_out_oe_o = (clk_src_o != SCC_SRC_NONE);

  AST_RESAMPLE_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    $fell(subsys_reset_o) && mode_r |-> pin_resample_req_o)
    else $error("resample request missing");
  AST_RELOAD_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    $fell(subsys_reset_o) && !mode_r |-> pin_reload_req_o && !pin_resample_req_o)
    else $error("reload request missing");
  AST_SEL_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    mgmt_rsp_o.ack && mgmt_rsp_o.hit |-> mgmt_rsp_o.rdata[15:6] == 10'h000)
    else $error("reserved bits not zero");
  AST_RCVR_FAST: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    clk_cfg_r[5] |=> clk_src_o == SCC_SRC_RCVR_FAST || $changed(clk_cfg_r))
    else $error("recovered fast clock not selected");
  AST_FREE_FAST: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    clk_cfg_r[5:4] == 2'b01 && $stable(clk_cfg_r) |=> clk_src_o == SCC_SRC_FREE_FAST)
    else $error("free fast clock not selected");
  AST_REF_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    clk_cfg_r == 6'h01 ##1 clk_cfg_r == 6'h01 |->
    general_clock_out_oe_o && clk_src_o == SCC_SRC_REF)
    else $error("reference clock not selected");
  AST_RCVR_HRT: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    clk_cfg_r[5:4] == 2'b00 && clk_cfg_r[2] |=> clk_src_o == SCC_SRC_RCVR_HRT)
    else $error("recovered heartbeat not selected");
  AST_FREE_HRT: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    clk_cfg_r[5:4] == 2'b00 && clk_cfg_r[2:1] == 2'b01 |=> clk_src_o == SCC_SRC_FREE_HRT)
    else $error("free heartbeat not selected");
  AST_SEL_RSVD: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    hit && mgmt_req_i.addr == `SCC_ADDR_RESAMPLE_SEL |=> mgmt_rsp_o.rdata[15:1] == 15'h0000)
    else $error("selector reserved bits not zero");
  AST_MODE_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    state_r == SCC_ST_IDLE && wr_en && mgmt_req_i.addr == `SCC_ADDR_SOFT_RESET &&
    mgmt_req_i.wdata[0] |=> mode_r == $past(resample_sel_r))
    else $error("selector not captured at trigger");
  AST_BUSY_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    hit && mgmt_req_i.addr == `SCC_ADDR_SOFT_RESET && state_r != SCC_ST_IDLE |=>
    mgmt_rsp_o.rdata == 16'h0001)
    else $error("busy soft reset not reported");
  AST_SOFT_RESET: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    state_r == SCC_ST_IDLE && wr_en && mgmt_req_i.addr == `SCC_ADDR_SOFT_RESET &&
    mgmt_req_i.wdata[0] |=> subsys_reset_o [*8] ##1 !subsys_reset_o)
    else $error("soft reset length wrong");
  AST_NO_SOURCE: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    clk_cfg_r[5:0] == 6'h00 ##1 $stable(clk_cfg_r) |-> !general_clock_out_oe_o)
    else $error("clock pin driven with no source");
  AST_OTHER_MMD: assert property (@(posedge sys_clk_i) disable iff (!rst_s2_r)
    mgmt_req_i.req && mgmt_req_i.mmd != `SCC_MMD_SUBSYS |=> mgmt_rsp_o.ack && !mgmt_rsp_o.hit)
    else $error("foreign device address answered");
endmodule // scc_subsys_clk_rst

// *** verification/scc_host_model.sv ***
`timescale 1ns/1ps
module scc_host_model
  import scc_pkg::*;
(
  // Bus side
  input wire logic sys_clk_i,
  input wire scc_mgmt_rsp_type mgmt_rsp_i,
  output scc_mgmt_req_type mgmt_req_o
);
  initial mgmt_req_o = '0;
  // One access: a one-cycle request, then the answer taken on the ack edge
  task automatic access(input logic wr, input logic [4:0] mmd, input logic [15:0] addr,
      input logic [15:0] wd, output scc_mgmt_rsp_type rsp);
    rsp = '0;
    @(posedge sys_clk_i);
    mgmt_req_o <= '{1'b1, wr, mmd, addr, wd};
    @(posedge sys_clk_i);
    // Released fields carry inverted junk so a stale value cannot pass
    mgmt_req_o <= '{1'b0, ~wr, ~mmd, ~addr, ~wd};
    for (int n = 0; n < 4; n++) begin
      if (mgmt_rsp_i.ack === 1'b1) begin
        rsp = mgmt_rsp_i;
        break;
      end
      @(posedge sys_clk_i);
    end
  endtask
endmodule // scc_host_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "scc_map.svh"
module tb_top;
  import scc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] src_r = 5'h00;
  scc_mgmt_req_type req;
  scc_mgmt_rsp_type rsp;
  scc_src_type src;
  logic pin, oe, srst, rsmp, rld;
  int n_errors = 0;
  int n_compared = 0;
  int n_busy = 0;
  int bits[5] = '{5, 4, 2, 1, 0};
  logic [2:0] codes[5] = '{3'h7, 3'h6, 3'h2, 3'h3, 3'h1};
  initial forever #5 sys_clk_i = ~sys_clk_i;
  // Sources toggle at distinct rates so a wrong pick shows within 32 cycles
  always @(posedge sys_clk_i) src_r <= src_r + 5'h01;
  scc_subsys_clk_rst u_scc_subsys_clk_rst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .mgmt_req_i(req), .mgmt_rsp_o(rsp), .rcvr_fast_clk_i(src_r[0]),
    .free_fast_clk_i(src_r[1]), .rcvr_hrt_clk_i(src_r[2]), .free_hrt_clk_i(src_r[3]),
    .ref_clk_i(src_r[4]), .general_clock_out_pin_o(pin), .general_clock_out_oe_o(oe),
    .clk_src_o(src), .subsys_reset_o(srst), .pin_resample_req_o(rsmp),
    .pin_reload_req_o(rld));
  scc_host_model u_scc_host_model (.sys_clk_i(sys_clk_i), .mgmt_rsp_i(rsp), .mgmt_req_o(req));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] m, input logic [15:0] a,
      input logic [15:0] d, output scc_mgmt_rsp_type r);
    u_scc_host_model.access(w, m, a, d, r);
    if (r.ack !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t no ack", $time);
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [4:0] m, input logic [15:0] a, input logic h,
      input logic [15:0] e);
    scc_mgmt_rsp_type r;
    acc(1'b0, m, a, 16'h0000, r);
    chk({15'h0000, r.hit}, {15'h0000, h}, "hit");
    chk(r.rdata, e, "rdata");
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    scc_mgmt_rsp_type r;
    acc(1'b1, `SCC_MMD_SUBSYS, a, d, r);
  endtask
  task automatic chk_out(input logic [2:0] code, input int k);
    repeat (2) @(posedge sys_clk_i);
    chk({13'h0000, src}, {13'h0000, code}, "source");
    chk({15'h0000, oe}, {15'h0000, code != 3'h0}, "enable");
    repeat (32) begin
      @(negedge sys_clk_i);
      chk({15'h0000, pin}, {15'h0000, (code == 3'h0) ? 1'b0 : src_r[k]}, "pin");
    end
  endtask
  task automatic soft_rst(input logic sel);
    int nr, np, nl;
    nr = 0;
    np = 0;
    nl = 0;
    wr(`SCC_ADDR_RESAMPLE_SEL, {15'h7FFF, sel});
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_RESAMPLE_SEL, 1'b1, {15'h0000, sel});
    wr(`SCC_ADDR_SOFT_RESET, 16'h0001);
    repeat (12) begin
      nr += int'(srst === 1'b1);
      np += int'(rsmp === 1'b1);
      nl += int'(rld === 1'b1);
      @(posedge sys_clk_i);
    end
    chk(16'(nr), 16'h0008, "reset length");
    chk(16'(np), {15'h0000, sel}, "resample");
    chk(16'(nl), {15'h0000, ~sel}, "reload");
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_SOFT_RESET, 1'b1, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_SOFT_RESET, 1'b1, 16'h0000);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_RESAMPLE_SEL, 1'b1, 16'h0000);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_CLK_OUT_CFG, 1'b1, 16'h0000);
    chk_out(3'h0, 0);
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) begin
      wr(`SCC_ADDR_CLK_OUT_CFG, 16'h0001 << bits[i]);
      chk_out(codes[i], i);
    end
    wr(`SCC_ADDR_CLK_OUT_CFG, 16'hFFFF);
    chk_out(3'h7, 0);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_CLK_OUT_CFG, 1'b1, 16'h003F);
    wr(`SCC_ADDR_CLK_OUT_CFG, 16'h0016);
    chk_out(3'h6, 1);
    wr(`SCC_ADDR_CLK_OUT_CFG, 16'hFFC8);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_CLK_OUT_CFG, 1'b1, 16'h0008);
    chk_out(3'h0, 0);
    $display("test clock_select done");
    soft_rst(1'b1);
    soft_rst(1'b0);
    $display("test soft_reset done");
    wr(`SCC_ADDR_SOFT_RESET, 16'h0001);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_SOFT_RESET, 1'b1, 16'h0001);
    wr(`SCC_ADDR_SOFT_RESET, 16'h0001);
    repeat (3) @(posedge sys_clk_i);
    repeat (12) begin
      n_busy += int'(srst === 1'b1);
      @(posedge sys_clk_i);
    end
    chk(16'(n_busy), 16'h0000, "retrigger while busy");
    $display("test busy done");
    wr(`SCC_ADDR_CLK_OUT_CFG, 16'h0021);
    wr(`SCC_ADDR_RESAMPLE_SEL, 16'h0001);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_CLK_OUT_CFG, 1'b1, 16'h0021);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_RESAMPLE_SEL, 1'b1, 16'h0000);
    rd(`SCC_MMD_SUBSYS, `SCC_ADDR_CLK_OUT_CFG, 1'b1, 16'h0000);
    chk_out(3'h0, 0);
    $display("test mid_run_reset done");
    rd(5'h01, `SCC_ADDR_CLK_OUT_CFG, 1'b0, 16'h0000);
    rd(`SCC_MMD_SUBSYS, 16'hFF0E, 1'b0, 16'h0000);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule // tb_top
